// *** rtl/haptic_pkg.sv ***
package haptic_pkg;
  // Mode codes
  localparam logic [1:0] MODE_REALTIME = 2'h0;
  localparam logic [1:0] MODE_SEQUENCER = 2'h1;
  localparam logic [1:0] MODE_DIAG = 2'h2;
  localparam logic [1:0] MODE_CAL = 2'h3;
  // Trigger pin functions
  localparam logic [1:0] TRIG_PULSE = 2'h0;
  localparam logic [1:0] TRIG_LEVEL = 2'h1;
  // Clock and time base
  localparam int CLOCK_HZ = 200000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLOCK_HZ / MS_PER_S;
  // Calibration waveform lengths, ms
  localparam logic [10:0] CAL_LEN_0_MS = 11'd250;
  localparam logic [10:0] CAL_LEN_1_MS = 11'd500;
  localparam logic [10:0] CAL_LEN_2_MS = 11'd1000;
  localparam logic [1:0] CAL_LEN_TRIG = 2'h3;
  localparam logic [10:0] CAL_MIN_TRIG_MS = 11'd1000;
  // Overdrive time limits, ms
  localparam logic [10:0] OD_LIMIT_0_MS = 11'd20;
  localparam logic [10:0] OD_LIMIT_1_MS = 11'd40;
  localparam logic [10:0] OD_LIMIT_2_MS = 11'd60;
  localparam logic [10:0] OD_LIMIT_3_MS = 11'd80;
  // Sequencer and diagnostic run lengths, ms
  localparam int SEQ_MS_DEF = 100;
  localparam logic [10:0] DIAG_MS = 11'd1;
  localparam logic [10:0] MS_SAT = 11'h7ff;
  // Host-side command map
  localparam logic [3:0] H_MODE = 4'h0;
  localparam logic [3:0] H_LOOP = 4'h1;
  localparam logic [3:0] H_GAIN = 4'h2;
  localparam logic [3:0] H_RATED = 4'h3;
  localparam logic [3:0] H_PEAK = 4'h4;
  localparam logic [3:0] H_FALLBACK = 4'h5;
  localparam logic [3:0] H_TIMING = 4'h6;
  localparam logic [3:0] H_LRA = 4'h7;
  localparam logic [3:0] H_RT_AMP = 4'h8;
  localparam logic [3:0] H_RUN = 4'h9;
  localparam logic [3:0] H_PIN = 4'ha;
  localparam logic [3:0] H_STATUS = 4'hb;
  localparam logic [3:0] H_CAL_COMP = 4'hc;
  localparam logic [3:0] H_CAL_BEMF = 4'hd;
  localparam logic [3:0] H_CAL_PERIOD = 4'he;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Typical calibration inputs loaded at reset
  localparam logic [2:0] RST_BRAKE_GAIN = 3'h3;
  localparam logic [1:0] RST_LOOP_GAIN = 2'h2;
  localparam logic [1:0] RST_SAMPLE_LEN = 2'h3;
  localparam logic [3:0] RST_BLANK_LEN = 4'h1;
  localparam logic [3:0] RST_DISSIPATE_LEN = 4'h1;
  localparam logic [1:0] RST_ZERO_CROSS = 2'h0;
endpackage

// *** rtl/haptic_if.sv ***
`timescale 1ns/1ps
interface haptic_if;
  logic [1:0] mode;
  logic [1:0] trigger_pin_function;
  logic actuator_type_sel;
  logic open_loop;
  logic auto_brake_ol;
  logic [2:0] feedback_brake_gain;
  logic [1:0] loop_gain;
  logic [1:0] sample_len;
  logic [7:0] rated_level;
  logic [7:0] peak_drive_limit;
  logic [7:0] fallback_clamp;
  logic [1:0] overdrive_time_limit;
  logic [1:0] cal_len_sel;
  logic [3:0] drive_time;
  logic [3:0] feedback_blank_len;
  logic [3:0] current_dissipate_len;
  logic [1:0] zero_cross_detect_len;
  logic [7:0] realtime_amplitude;
  logic run_write;
  logic run_wdata;
  logic trigger_irq_pin;
  logic run_status;
  logic fault_result_flag;
  logic [7:0] cal_comp;
  logic [7:0] cal_bemf;
  logic [7:0] cal_period;
  modport dev (
    input mode, trigger_pin_function, actuator_type_sel, open_loop,
    input auto_brake_ol, feedback_brake_gain, loop_gain, sample_len,
    input rated_level, peak_drive_limit, fallback_clamp,
    input overdrive_time_limit, cal_len_sel, drive_time,
    input feedback_blank_len, current_dissipate_len,
    input zero_cross_detect_len, realtime_amplitude,
    input run_write, run_wdata, trigger_irq_pin,
    output run_status, fault_result_flag, cal_comp, cal_bemf, cal_period
  );
  modport host (
    output mode, trigger_pin_function, actuator_type_sel, open_loop,
    output auto_brake_ol, feedback_brake_gain, loop_gain, sample_len,
    output rated_level, peak_drive_limit, fallback_clamp,
    output overdrive_time_limit, cal_len_sel, drive_time,
    output feedback_blank_len, current_dissipate_len,
    output zero_cross_detect_len, realtime_amplitude,
    output run_write, run_wdata, trigger_irq_pin,
    input run_status, fault_result_flag, cal_comp, cal_bemf, cal_period
  );
endinterface

// *** rtl/haptic_dev.sv ***
`timescale 1ns/1ps
module haptic_dev #(
  parameter int MS_CYCLES = haptic_pkg::MS_CYCLES_DEF,
  parameter int SEQ_MS = haptic_pkg::SEQ_MS_DEF
) (
  input wire clock,
  input wire reset,
  haptic_if.dev link,
  input wire enable_pin,
  output logic [7:0] drive_level,
  output logic drive_negative,
  output logic braking,
  output logic active
);
  // Millisecond counters are 11 bits and saturate
  if (MS_CYCLES < 2 || SEQ_MS < 1 || SEQ_MS > 2046)
  begin
    $error("haptic_dev: unsupported parameter values");
  end

  typedef enum {st_idle, st_cal, st_rt, st_seq, st_diag} run_state_e;
  run_state_e state;

  logic [31:0] div_count;
  logic ms_tick;
  logic [10:0] run_ms;
  logic [10:0] od_ms;
  logic od_dir;
  logic pin_prev;
  logic [1:0] mode_prev;
  logic pin_rise;
  logic pin_fall;
  logic level_fn;
  logic start_req;
  logic stop_req;
  logic cal_done;
  logic [10:0] cal_len;
  logic [10:0] od_limit;
  logic [7:0] amp;
  logic [8:0] mag;
  logic [16:0] prod;
  logic [7:0] scaled;
  logic [7:0] fallback_lvl;
  logic od_expired;
  logic [7:0] next_level;
  logic next_negative;
  logic next_braking;

  // Millisecond enable shared by every timer
  always_ff @(posedge clock)
  begin
    if (reset || div_count == 32'(MS_CYCLES - 1))
      div_count <= '0;
    else
      div_count <= div_count + 32'h1;
  end
  assign ms_tick = (div_count == 32'(MS_CYCLES - 1));

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pin_prev <= 1'b0;
      mode_prev <= haptic_pkg::MODE_REALTIME;
    end
    else
    begin
      pin_prev <= link.trigger_irq_pin;
      mode_prev <= link.mode;
    end
  end

  assign pin_rise = link.trigger_irq_pin && !pin_prev;
  assign pin_fall = !link.trigger_irq_pin && pin_prev;
  assign level_fn = (link.trigger_pin_function == haptic_pkg::TRIG_LEVEL);
  // Pulse function: a second pulse stops; level function: low edge stops
  assign start_req = (link.run_write && link.run_wdata && !level_fn)
    || (pin_rise && link.trigger_pin_function <= haptic_pkg::TRIG_LEVEL);
  assign stop_req = (link.run_write && !link.run_wdata && !level_fn)
    || (link.trigger_pin_function == haptic_pkg::TRIG_PULSE && pin_rise)
    || (level_fn && pin_fall);

  always_comb
  begin
    case (link.cal_len_sel)
      2'h0: cal_len = haptic_pkg::CAL_LEN_0_MS;
      2'h1: cal_len = haptic_pkg::CAL_LEN_1_MS;
      2'h2: cal_len = haptic_pkg::CAL_LEN_2_MS;
      default: cal_len = haptic_pkg::MS_SAT;
    endcase
    case (link.overdrive_time_limit)
      2'h0: od_limit = haptic_pkg::OD_LIMIT_0_MS;
      2'h1: od_limit = haptic_pkg::OD_LIMIT_1_MS;
      2'h2: od_limit = haptic_pkg::OD_LIMIT_2_MS;
      default: od_limit = haptic_pkg::OD_LIMIT_3_MS;
    endcase
  end

  assign cal_done = (state == st_cal) &&
    ((link.cal_len_sel == haptic_pkg::CAL_LEN_TRIG) ? stop_req
      : (run_ms >= cal_len));

  // Sequencer content is outside this block; it runs a fixed time
  always_ff @(posedge clock)
  begin
    if (reset)
      state <= st_idle;
    else
      case (state)
        st_idle:
          if (start_req && enable_pin)
            case (link.mode)
              haptic_pkg::MODE_CAL: state <= st_cal;
              haptic_pkg::MODE_REALTIME: state <= st_rt;
              haptic_pkg::MODE_SEQUENCER: state <= st_seq;
              default: state <= st_diag;
            endcase
        st_cal:
          if (cal_done || !enable_pin)
            state <= st_idle;
        st_rt:
          if (stop_req || link.mode != mode_prev || !enable_pin)
            state <= st_idle;
        st_seq:
          if (stop_req || run_ms >= 11'(SEQ_MS) || !enable_pin)
            state <= st_idle;
        st_diag:
          if (stop_req || run_ms >= haptic_pkg::DIAG_MS || !enable_pin)
            state <= st_idle;
        default: state <= st_idle;
      endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset || state == st_idle)
      run_ms <= '0;
    else if (ms_tick && run_ms != haptic_pkg::MS_SAT)
      run_ms <= run_ms + 11'h1;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      link.run_status <= 1'b0;
    else
      link.run_status <= (state != st_idle);
  end

  // Results reset only with the device; standby leaves them alone
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      link.cal_comp <= haptic_pkg::RST_BYTE;
      link.cal_bemf <= haptic_pkg::RST_BYTE;
      link.cal_period <= haptic_pkg::RST_BYTE;
      link.fault_result_flag <= 1'b0;
    end
    else if (cal_done)
    begin
      link.cal_comp <= link.rated_level;
      link.cal_bemf <= {link.feedback_brake_gain, link.loop_gain,
        link.sample_len, 1'b0};
      link.cal_period <= link.actuator_type_sel ? haptic_pkg::RST_BYTE
        : {link.feedback_blank_len, link.current_dissipate_len};
      // Short triggered runs give unreliable results
      link.fault_result_flag <= (link.peak_drive_limit < link.rated_level)
        || (link.cal_len_sel == haptic_pkg::CAL_LEN_TRIG
          && run_ms < haptic_pkg::CAL_MIN_TRIG_MS);
    end
  end

  assign amp = (state == st_rt) ? link.realtime_amplitude
    : (state == st_cal) ? 8'h7f : 8'h00;
  assign mag = amp[7] ? 9'(-$signed({amp[7], amp})) : {1'b0, amp};
  assign prod = mag * (link.open_loop ? link.peak_drive_limit
    : link.rated_level);
  assign scaled = prod[16:15] != 2'h0 ? 8'hff : prod[14:7];
  assign fallback_lvl = link.fallback_clamp < link.peak_drive_limit
    ? link.fallback_clamp : link.peak_drive_limit;
  assign od_expired = (od_ms >= od_limit);

  // Overdrive time is counted per direction; a reversal restarts it
  always_ff @(posedge clock)
  begin
    if (reset || state == st_idle || link.open_loop)
    begin
      od_ms <= '0;
      od_dir <= 1'b0;
    end
    else if (od_dir != next_braking)
    begin
      od_ms <= '0;
      od_dir <= next_braking;
    end
    else if (ms_tick && !od_expired)
      od_ms <= od_ms + 11'h1;
  end

  always_comb
  begin
    next_level = 8'h00;
    next_negative = 1'b0;
    next_braking = 1'b0;
    if (state == st_rt || state == st_cal)
    begin
      if (link.open_loop)
      begin
        next_level = scaled < link.peak_drive_limit ? scaled
          : link.peak_drive_limit;
        next_negative = amp[7] && !link.auto_brake_ol;
        next_braking = amp[7] && link.auto_brake_ol;
      end
      else
      begin
        next_braking = amp[7] || amp == 8'h00;
        if (od_dir != next_braking)
          next_level = link.peak_drive_limit;
        else if (!od_expired)
          next_level = link.peak_drive_limit;
        else if (next_braking)
          next_level = fallback_lvl;
        else
          next_level = scaled < fallback_lvl ? scaled : fallback_lvl;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      drive_level <= 8'h00;
      drive_negative <= 1'b0;
      braking <= 1'b0;
      active <= 1'b0;
    end
    else
    begin
      drive_level <= next_level;
      drive_negative <= next_negative;
      braking <= next_braking;
      active <= (state != st_idle);
    end
  end
endmodule

// *** rtl/haptic_host.sv ***
`timescale 1ns/1ps
module haptic_host (
  input wire clock,
  input wire reset,
  haptic_if.host link,
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [3:0] rd_addr,
  output logic [7:0] rd_data
);
  // Every field is a flop so the device always sees stable settings
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      link.mode <= haptic_pkg::MODE_REALTIME;
      link.trigger_pin_function <= haptic_pkg::TRIG_PULSE;
      link.actuator_type_sel <= 1'b0;
      link.open_loop <= 1'b0;
      link.auto_brake_ol <= 1'b0;
      link.feedback_brake_gain <= haptic_pkg::RST_BRAKE_GAIN;
      link.loop_gain <= haptic_pkg::RST_LOOP_GAIN;
      link.sample_len <= haptic_pkg::RST_SAMPLE_LEN;
      link.rated_level <= haptic_pkg::RST_BYTE;
      link.peak_drive_limit <= haptic_pkg::RST_BYTE;
      link.fallback_clamp <= haptic_pkg::RST_BYTE;
      link.overdrive_time_limit <= 2'h0;
      link.cal_len_sel <= haptic_pkg::CAL_LEN_TRIG;
      link.drive_time <= 4'h0;
      link.feedback_blank_len <= haptic_pkg::RST_BLANK_LEN;
      link.current_dissipate_len <= haptic_pkg::RST_DISSIPATE_LEN;
      link.zero_cross_detect_len <= haptic_pkg::RST_ZERO_CROSS;
      link.realtime_amplitude <= haptic_pkg::RST_BYTE;
      link.trigger_irq_pin <= 1'b0;
    end
    else if (wr_en)
      case (wr_addr)
        haptic_pkg::H_MODE:
        begin
          link.mode <= wr_data[1:0];
          link.trigger_pin_function <= wr_data[3:2];
          link.actuator_type_sel <= wr_data[4];
          link.open_loop <= wr_data[5];
          link.auto_brake_ol <= wr_data[6];
        end
        haptic_pkg::H_LOOP:
        begin
          link.feedback_brake_gain <= wr_data[2:0];
          link.loop_gain <= wr_data[4:3];
          link.sample_len <= wr_data[6:5];
        end
        haptic_pkg::H_GAIN:
        begin
          link.overdrive_time_limit <= wr_data[1:0];
          link.cal_len_sel <= wr_data[3:2];
          link.drive_time <= wr_data[7:4];
        end
        haptic_pkg::H_RATED: link.rated_level <= wr_data;
        haptic_pkg::H_PEAK: link.peak_drive_limit <= wr_data;
        haptic_pkg::H_FALLBACK: link.fallback_clamp <= wr_data;
        haptic_pkg::H_LRA:
        begin
          link.feedback_blank_len <= wr_data[3:0];
          link.current_dissipate_len <= wr_data[7:4];
        end
        haptic_pkg::H_TIMING: link.zero_cross_detect_len <= wr_data[1:0];
        haptic_pkg::H_RT_AMP: link.realtime_amplitude <= wr_data;
        haptic_pkg::H_PIN: link.trigger_irq_pin <= wr_data[0];
        default: ;
      endcase
  end

  // Run bit write is a one-cycle command, not a stored level
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      link.run_write <= 1'b0;
      link.run_wdata <= 1'b0;
    end
    else
    begin
      link.run_write <= wr_en && wr_addr == haptic_pkg::H_RUN;
      link.run_wdata <= wr_data[0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      rd_data <= haptic_pkg::RST_BYTE;
    else
      case (rd_addr)
        haptic_pkg::H_RUN: rd_data <= {7'h00, link.run_status};
        haptic_pkg::H_STATUS:
          rd_data <= {6'h00, link.fault_result_flag, link.run_status};
        haptic_pkg::H_CAL_COMP: rd_data <= link.cal_comp;
        haptic_pkg::H_CAL_BEMF: rd_data <= link.cal_bemf;
        haptic_pkg::H_CAL_PERIOD: rd_data <= link.cal_period;
        haptic_pkg::H_RT_AMP: rd_data <= link.realtime_amplitude;
        default: rd_data <= 8'h00;
      endcase
  end
endmodule

// *** bench/haptic_link_asserts.sv ***
`timescale 1ns/1ps
module haptic_link_asserts #(
  parameter int MS_CYCLES = haptic_pkg::MS_CYCLES_DEF
) (
  input logic clock,
  input logic reset,
  input logic [1:0] mode,
  input logic [1:0] trigger_pin_function,
  input logic actuator_type_sel,
  input logic [2:0] feedback_brake_gain,
  input logic [1:0] loop_gain,
  input logic [1:0] sample_len,
  input logic [7:0] rated_level,
  input logic [7:0] peak_drive_limit,
  input logic [1:0] cal_len_sel,
  input logic [3:0] feedback_blank_len,
  input logic [3:0] current_dissipate_len,
  input logic run_write,
  input logic run_wdata,
  input logic trigger_irq_pin,
  input logic run_status,
  input logic fault_result_flag,
  input logic [7:0] cal_comp,
  input logic [7:0] cal_bemf,
  input logic [7:0] cal_period
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  int run_cycles;
  logic [10:0] len_ms;
  logic cal_mode;
  assign cal_mode = (mode == haptic_pkg::MODE_CAL);
  assign len_ms = (cal_len_sel == 2'h0) ? haptic_pkg::CAL_LEN_0_MS :
    (cal_len_sel == 2'h1) ? haptic_pkg::CAL_LEN_1_MS :
    haptic_pkg::CAL_LEN_2_MS;
  // Tick phase at start can cut up to one ms off the run, never lengthen it
  always_ff @(posedge clock)
  begin
    if (reset || !run_status)
      run_cycles <= 0;
    else
      run_cycles <= run_cycles + 1;
  end
  cal_length_a: assert property (
    $fell(run_status) && cal_mode && cal_len_sel != 2'h3
    |-> run_cycles >= int'(len_ms) * MS_CYCLES - MS_CYCLES - 2 &&
    run_cycles <= int'(len_ms) * MS_CYCLES + MS_CYCLES + 2)
    else $error("calibration length off");
  results_hold_a: assert property (
    $changed(cal_comp) |-> run_status ##1 !run_status)
    else $error("results changed outside calibration end");
  cal_results_a: assert property (
    $fell(run_status) && cal_mode |-> cal_comp == rated_level &&
    cal_period == (actuator_type_sel ? 8'h00 :
    {feedback_blank_len, current_dissipate_len}))
    else $error("calibration results wrong");
  bemf_packing_a: assert property (
    $fell(run_status) && cal_mode
    |-> cal_bemf == {feedback_brake_gain, loop_gain, sample_len, 1'b0})
    else $error("bemf result wrong");
  fault_rule_a: assert property (
    $fell(run_status) && cal_mode && cal_len_sel != 2'h3
    |-> fault_result_flag == (peak_drive_limit < rated_level))
    else $error("fault flag wrong");
  run_stop_a: assert property (
    run_write && !run_wdata && run_status &&
    trigger_pin_function != haptic_pkg::TRIG_LEVEL |-> ##[1:3] !run_status)
    else $error("run write of zero did not stop");
  mode_change_stop_a: assert property (
    $past(mode) == haptic_pkg::MODE_REALTIME &&
    mode != haptic_pkg::MODE_REALTIME && run_status
    |-> ##[1:3] !run_status)
    else $error("mode change did not stop playback");
  level_run_ignored_a: assert property (
    (trigger_pin_function == haptic_pkg::TRIG_LEVEL && !trigger_irq_pin)[*6]
    |-> !$rose(run_status))
    else $error("start without pin in level mode");
  cover property ($fell(run_status) && cal_mode);
  cover property (mode == haptic_pkg::MODE_REALTIME && $rose(run_status));
  cover property (trigger_pin_function == haptic_pkg::TRIG_LEVEL &&
    $rose(run_status));
endmodule

// *** bench/haptic_calibration_playback_ctrl_test.sv ***
`timescale 1ns/1ps
module haptic_calibration_playback_ctrl_test;
  localparam int MS = 4;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic enable_pin = 1'b1;
  logic wr_en = 1'b0;
  logic [3:0] wr_addr = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic [3:0] rd_addr = 4'h0;
  logic [7:0] rd_data, drive_level, rated, lra, amp, old;
  logic drive_negative, braking, active;
  logic [31:0] seed = 32'h9be8;
  int n_mismatch = 0;
  int checks_done = 0;
  int cnt;
  haptic_if link();
  haptic_host u_haptic_host (.clock(clock), .reset(reset), .link(link),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data));
  haptic_dev #(.MS_CYCLES(MS), .SEQ_MS(5)) u_haptic_dev (.clock(clock),
    .reset(reset), .link(link), .enable_pin(enable_pin),
    .drive_level(drive_level), .drive_negative(drive_negative),
    .braking(braking), .active(active));
  haptic_link_asserts #(.MS_CYCLES(MS)) u_haptic_link_asserts (
    .clock(clock), .reset(reset), .mode(link.mode),
    .trigger_pin_function(link.trigger_pin_function),
    .actuator_type_sel(link.actuator_type_sel),
    .feedback_brake_gain(link.feedback_brake_gain),
    .loop_gain(link.loop_gain), .sample_len(link.sample_len),
    .rated_level(link.rated_level), .peak_drive_limit(link.peak_drive_limit),
    .cal_len_sel(link.cal_len_sel),
    .feedback_blank_len(link.feedback_blank_len),
    .current_dissipate_len(link.current_dissipate_len),
    .run_write(link.run_write), .run_wdata(link.run_wdata),
    .trigger_irq_pin(link.trigger_irq_pin), .run_status(link.run_status),
    .fault_result_flag(link.fault_result_flag), .cal_comp(link.cal_comp),
    .cal_bemf(link.cal_bemf), .cal_period(link.cal_period));
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] scaled(input logic [7:0] a,
                                        input logic [7:0] lvl);
    logic [15:0] mag;
    mag = {8'h00, a[7] ? 8'(-a) : a};
    return 8'((mag * {8'h00, lvl}) >> 7);
  endfunction
  function automatic int len_ms(input logic [1:0] code);
    return (code == 2'h0) ? 250 : (code == 2'h1) ? 500 : 1000;
  endfunction
  task automatic results();
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] act);
    checks_done++;
    if (act !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t exp %h got %h", $time, exp, act);
    end
  endtask
  task automatic chk1(input logic exp, input logic act);
    chk({7'h0, exp}, {7'h0, act});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge clock);
    #1;
    wr_en = 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    #1;
    rd_addr = a;
    @(posedge clock);
    #1;
    chk(exp, rd_data);
  endtask
  // Bounded wait; a miss shows as a mismatch on active
  task automatic wait_act(input logic v, input int limit);
    cnt = 0;
    while (active !== v && cnt < limit)
    begin
      @(posedge clock);
      #1;
      cnt++;
    end
    chk1(v, active);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cal_setup(input logic typ, input logic [1:0] code);
    wr(haptic_pkg::H_MODE, {3'h0, typ, 4'h3});
    wr(haptic_pkg::H_LOOP, 8'h73);
    wr(haptic_pkg::H_RATED, rated);
    wr(haptic_pkg::H_PEAK, 8'hf0);
    wr(haptic_pkg::H_GAIN, {4'h5, code, 2'h0});
    wr(haptic_pkg::H_LRA, lra);
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    results();
  end
  initial
  begin
    settle(5);
    reset = 1'b0;
    rd_chk(haptic_pkg::H_STATUS, 8'h00);
    rd_chk(haptic_pkg::H_CAL_COMP, 8'h00);
    rd_chk(4'hf, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      rated = {1'b0, 7'(rnd())};
      lra = 8'(rnd());
      cal_setup(i == 3, (i == 3) ? 2'h0 : 2'(i));
      if (i == 1)
        wr(haptic_pkg::H_PEAK, 8'h05);
      wr(haptic_pkg::H_RUN, 8'h01);
      wait_act(1'b1, 8);
      rd_chk(haptic_pkg::H_RUN, 8'h01);
      wait_act(1'b0, 5000);
      cnt = cnt + 2 - len_ms((i == 3) ? 2'h0 : 2'(i)) * MS;
      chk1(1'b1, cnt >= -MS - 4 && cnt <= MS + 4);
      rd_chk(haptic_pkg::H_RUN, 8'h00);
      rd_chk(haptic_pkg::H_STATUS,
        {6'h00, i == 1 && rated > 8'h05, 1'b0});
      rd_chk(haptic_pkg::H_CAL_COMP, rated);
      rd_chk(haptic_pkg::H_CAL_BEMF, 8'h76);
      rd_chk(haptic_pkg::H_CAL_PERIOD,
        (i == 3) ? 8'h00 : {lra[3:0], lra[7:4]});
    end
    old = rated;
    rated = 8'hda;
    cal_setup(1'b0, 2'h3);
    wr(haptic_pkg::H_PIN, 8'h01);
    wr(haptic_pkg::H_PIN, 8'h00);
    wait_act(1'b1, 8);
    settle(1002 * MS);
    rd_chk(haptic_pkg::H_CAL_COMP, old);
    wr(haptic_pkg::H_PIN, 8'h01);
    wr(haptic_pkg::H_PIN, 8'h00);
    wait_act(1'b0, 8);
    rd_chk(haptic_pkg::H_CAL_COMP, 8'hda);
    rd_chk(haptic_pkg::H_STATUS, 8'h00);
    wr(haptic_pkg::H_RUN, 8'h01);
    wait_act(1'b1, 8);
    settle(20);
    wr(haptic_pkg::H_RUN, 8'h00);
    wait_act(1'b0, 8);
    rd_chk(haptic_pkg::H_STATUS, 8'h02);
    enable_pin = 1'b0;
    wr(haptic_pkg::H_RUN, 8'h01);
    settle(6);
    chk1(1'b0, active);
    rd_chk(haptic_pkg::H_CAL_COMP, 8'hda);
    enable_pin = 1'b1;
    wr(haptic_pkg::H_PEAK, 8'hc8);
    wr(haptic_pkg::H_MODE, 8'h20);
    wr(haptic_pkg::H_RUN, 8'h01);
    wait_act(1'b1, 8);
    for (int i = 0; i < 8; i++)
    begin
      amp = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : (i == 2) ? 8'h00 :
        8'(rnd());
      wr(haptic_pkg::H_RT_AMP, amp);
      settle(3);
      chk(scaled(amp, 8'hc8), drive_level);
      chk1(amp[7], drive_negative);
      chk1(1'b0, braking);
    end
    wr(haptic_pkg::H_MODE, 8'h60);
    wr(haptic_pkg::H_RT_AMP, 8'hc0);
    settle(3);
    chk1(1'b1, braking);
    wr(haptic_pkg::H_MODE, 8'h61);
    wait_act(1'b0, 6);
    wr(haptic_pkg::H_RUN, 8'h01);
    wait_act(1'b1, 8);
    wait_act(1'b0, 5 * MS + 20);
    // Pin function 2 leaves the pin without effect
    wr(haptic_pkg::H_MODE, 8'h0a);
    wr(haptic_pkg::H_PIN, 8'h01);
    settle(6);
    chk1(1'b0, active);
    wr(haptic_pkg::H_PIN, 8'h00);
    wr(haptic_pkg::H_RUN, 8'h01);
    wait_act(1'b1, 8);
    wait_act(1'b0, 2 * MS + 8);
    wr(haptic_pkg::H_RATED, 8'h40);
    wr(haptic_pkg::H_PEAK, 8'hc0);
    wr(haptic_pkg::H_FALLBACK, 8'h30);
    wr(haptic_pkg::H_GAIN, 8'h0c);
    wr(haptic_pkg::H_MODE, 8'h00);
    wr(haptic_pkg::H_RT_AMP, 8'h7f);
    wr(haptic_pkg::H_RUN, 8'h01);
    wait_act(1'b1, 8);
    settle(10);
    chk(8'hc0, drive_level);
    settle(20 * MS + 10);
    chk(8'h30, drive_level);
    wr(haptic_pkg::H_RT_AMP, 8'h00);
    settle(3);
    chk1(1'b1, braking);
    wr(haptic_pkg::H_RUN, 8'h00);
    wait_act(1'b0, 6);
    wr(haptic_pkg::H_MODE, 8'h04);
    wr(haptic_pkg::H_RUN, 8'h01);
    settle(6);
    chk1(1'b0, active);
    wr(haptic_pkg::H_PIN, 8'h01);
    wait_act(1'b1, 8);
    wr(haptic_pkg::H_PIN, 8'h00);
    wait_act(1'b0, 8);
    results();
  end
endmodule
